/* File: inc/sfp_cyc_if.sv */
`timescale 1ns/1ns
// One flash bus cycle request and its completion
interface sfp_cyc_if;
  logic        req;
  logic        we;
  logic [17:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctl (output req, we, addr, wdata, input done, rdata);
  modport eng (input req, we, addr, wdata, output done, rdata);
endinterface

/* File: inc/sfp_pkg.sv */
package sfp_pkg;
  // Clock and pin timing
  localparam int CLK_NS    = 100;
  localparam int T_WP_NS   = 200;
  localparam int T_WPH_NS  = 200;
  localparam int T_ACC_NS  = 350;
  localparam int T_OEHP_NS = 150;
  localparam int T_BLC_US  = 150;
  localparam int T_WC_MS   = 20;
  localparam int SYNC_CYC  = 4;
  localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEHP_CYC  = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC    = ACC_CYC + SYNC_CYC;
  localparam int BLC_CYC   = (T_BLC_US * 1000) / CLK_NS;
  localparam int WC_CYC    = (T_WC_MS * 1000000) / CLK_NS;

  // Flash geometry
  localparam int FA_W       = 18;
  localparam int SECT_BYTES = 256;
  localparam int TOG_BIT    = 6;

  // Register offsets
  localparam logic [8:0] OFS_CTRL = 9'h000;
  localparam logic [8:0] OFS_ADDR = 9'h004;
  localparam logic [8:0] OFS_STAT = 9'h008;
  localparam logic [8:0] OFS_IST  = 9'h00c;
  localparam logic [8:0] OFS_ICLR = 9'h010;
  localparam logic [8:0] OFS_IEN  = 9'h014;

  // Status fields and interrupt bits
  localparam int ST_BUSY_POS = 0;
  localparam int ST_IDM_POS  = 1;
  localparam int ST_ERR_POS  = 2;
  localparam int ST_RD_POS   = 8;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_TMO     = 1;
  localparam logic [1:0] IEN_RST = 2'h0;

  // Command sequence words
  localparam logic [14:0] UNLK_A1     = 15'h0001;
  localparam logic [7:0]  UNLK_D1     = 8'h11;
  localparam logic [14:0] UNLK_A2     = 15'h0002;
  localparam logic [7:0]  UNLK_D2     = 8'h22;
  localparam logic [14:0] CMD_A       = 15'h0001;
  localparam logic [7:0]  CMD_PROG    = 8'h31;
  localparam logic [7:0]  CMD_ID_IN   = 8'h32;
  localparam logic [7:0]  CMD_ID_OUT  = 8'h33;
  localparam logic [7:0]  CMD_LOCK_LO = 8'h34;
  localparam logic [7:0]  CMD_LOCK_HI = 8'h35;

  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ID_IN, OP_ID_OUT, OP_LOCK_LO, OP_LOCK_HI
  } sfp_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_LOAD = 3'b011,
    ST_POLL = 3'b010, ST_FIN = 3'b110, ST_READ = 3'b100
  } sfp_st_t;

  typedef enum logic [1:0] {
    EG_IDLE = 2'b00, EG_SETUP = 2'b01, EG_STRB = 2'b11, EG_RECOV = 2'b10
  } sfp_eng_t;
endpackage

/* File: verification/sfp_flash_model.sv */
`timescale 1ns/1ns
module sfp_flash_model #(
  parameter int         BLC_NS  = 150000, // Load window
  parameter int         PROG_NS = 50000,  // Program time
  parameter logic [7:0] MAKER   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] PART    = 8'h6c   // Arbitrary value
) (
  input  wire logic        ce_n,    // Chip select
  input  wire logic        oe_n,    // Output strobe
  input  wire logic        we_n,    // Write strobe
  input  wire logic [17:0] a,       // Address
  input  wire logic [7:0]  hd,      // Host data
  input  wire logic        hd_oe_n, // Host drives when low
  output logic      [7:0]  q,       // Pin level
  output int               errs,    // Faults seen
  output logic             armed    // Load open
);
  import sfp_pkg::*;
  logic [7:0]  mem [0:262143];
  logic [7:0]  page [0:255];
  logic [7:0]  val, last;
  logic [9:0]  sect;
  logic [17:0] pa;
  logic [1:0]  seq;
  logic        idm, lk_lo, lk_hi, busy, tog, pv, sel;
  localparam logic [7:0] ERASE_CODE = 8'h36; // Arbitrary value
  int          cnt, gen;
  wire         drv  = !ce_n && !oe_n && we_n;
  wire         rd_n = ce_n | oe_n;
  wire         cmd  = a[14:0] == CMD_A;

  // Power-up: boot blocks unlocked, normal mode, erased
  initial begin
    {idm, lk_lo, lk_hi, busy, tog, pv, armed, sel} = 8'h00;
    {seq, errs, cnt, gen, last} = '0;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  // Read data source
  always @* begin
    if (busy) val = {1'b0, tog, 6'h00};
    else if (idm && a == 18'h00000) val = MAKER;
    else if (idm && a == 18'h00001) val = PART;
    else if (idm && a == 18'h00002) val = {7'h7f, lk_lo};
    else if (idm && a == 18'h3fff2) val = {7'h7f, lk_hi};
    else val = mem[a];
  end

  // Released pins show the inverse of the last level
  assign q = !hd_oe_n ? hd : drv ? val : ~last;
  always @(q) if (drv || !hd_oe_n) last = q;

  // Each strobed read while busy flips the toggle bit
  always @(negedge rd_n) if (busy) begin
    tog = ~tog;
    if (pv && a != pa) errs++;
    pa = a;
    pv = 1'b1;
  end

  // Select is latched at the falling strobe; chip select may rise with the strobe
  always @(negedge we_n) begin
    sel = !ce_n;
    if (sel && armed && cnt != 0 && a[17:8] != sect) errs++;
  end

  // Command decode and byte loads, ignored while busy
  always @(posedge we_n) if (sel && !busy) begin
    if (armed) begin
      if (cnt == 0) sect = a[17:8];
      page[a[7:0]] = hd;
      cnt++;
      gen++;
      fork
        window(gen);
      join_none
    end else if (seq == 2'd0) seq = (a[14:0] == UNLK_A1 && hd == UNLK_D1) ? 2'd1 : 2'd0;
    else if (seq == 2'd1) seq = (a[14:0] == UNLK_A2 && hd == UNLK_D2) ? 2'd2 : 2'd0;
    else begin
      seq = 2'd0;
      cnt = 0;
      if (cmd && hd == CMD_PROG) armed = 1'b1;
      if (cmd && hd == CMD_ID_IN) idm = 1'b1;
      if (cmd && hd == CMD_ID_OUT) idm = 1'b0;
      if (cmd && hd == CMD_LOCK_LO) lk_lo = 1'b1;
      if (cmd && hd == CMD_LOCK_HI) lk_hi = 1'b1;
      if (cmd && hd == ERASE_CODE && !lk_lo && !lk_hi)
        foreach (mem[i]) mem[i] = 8'hff;
      if (cmd && (hd == CMD_LOCK_LO || hd == CMD_LOCK_HI)) begin
        fork
          hold(PROG_NS / 5);
        join_none
      end
    end
  end

  // Busy span of an internal cycle
  task automatic hold(input int ns);
    pv = 1'b0;
    busy = 1'b1;
    #(ns);
    busy = 1'b0;
  endtask

  // Window expiry: program unless the sector is a locked boot block
  task automatic window(input int g);
    #(BLC_NS);
    if (g != gen) return;
    if (cnt != SECT_BYTES) errs++;
    armed = 1'b0;
    pv = 1'b0;
    busy = 1'b1;
    #(PROG_NS);
    // Array is written before busy drops so the first ready read sees it
    if (!(lk_lo && sect < 10'h020) && !(lk_hi && sect >= 10'h3e0))
      foreach (page[i]) mem[{sect, 8'(i)}] = page[i];
    busy = 1'b0;
  endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
  import sfp_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART  = 8'h6c; // Arbitrary value
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, armed;
  logic        flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [17:0] flash_a;
  logic [7:0]  flash_dq_i, flash_dq_o;
  int          errs, n_fail, samples_checked;

  sfp_host #(.WC_TMO_CYC(8000)) uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .flash_a,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_i, .flash_dq_o, .flash_dq_oe_n
  );
  sfp_flash_model #(.MAKER(MAKER), .PART(PART)) dev (
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .a(flash_a),
    .hd(flash_dq_o), .hd_oe_n(flash_dq_oe_n), .q(flash_dq_i), .errs, .armed
  );

  // Bus clock
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; ready and read data taken at rising edges
  task automatic xfer(input logic [8:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {23'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      r = hrdata;
    end while (hreadyout !== 1'b1);
  endtask

  task automatic chk_rd(input logic [8:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(r, exp);
  endtask

  // Start an operation and poll status until it is no longer busy
  task automatic op(input logic [2:0] code, input logic [17:0] fa);
    int i;
    xfer(OFS_ADDR, 1'b1, {14'h0, fa});
    xfer(OFS_CTRL, 1'b1, {29'h0, code});
    repeat (4) @(posedge hclk);
    i = 0;
    do begin
      xfer(OFS_STAT, 1'b0, 32'h0);
      i++;
    end while (r[ST_BUSY_POS] !== 1'b0 && i < 30000);
  endtask

  task automatic rdb(input logic [17:0] fa, input logic [7:0] exp);
    op(OP_READ, fa);
    chk(r[15:8], exp);
  endtask

  function automatic logic [7:0] pat(input int i, input logic [9:0] s);
    return 8'(i * 7) ^ s[7:0];
  endfunction

  // Fill the whole sector buffer, then program
  task automatic prog(input logic [9:0] s);
    for (int k = 0; k < 64; k++)
      xfer(9'h100 + 9'(4 * k), 1'b1, {pat(4*k+3, s), pat(4*k+2, s), pat(4*k+1, s), pat(4*k, s)});
    op(OP_PROG, {s, 8'h00});
  endtask

  task automatic id_reads(input logic [7:0] lo, input logic [7:0] hi);
    op(OP_ID_IN, 18'h0);
    chk(r[ST_IDM_POS], 1'b1);
    rdb(18'h00000, MAKER);
    rdb(18'h00001, PART);
    rdb(18'h00002, lo);
    rdb(18'h3fff2, hi);
    op(OP_ID_OUT, 18'h0);
    chk(r[ST_IDM_POS], 1'b0);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_rd(OFS_STAT, 32'h0);
    chk_rd(OFS_IEN, {30'h0, IEN_RST});
    chk_rd(9'h018, 32'h0);
    chk(hresp, 1'b0);
    xfer(OFS_IEN, 1'b1, 32'h1);
    prog(10'h123);
    chk_rd(OFS_IST, 32'h1);
    chk(irq, 1'b1);
    xfer(OFS_ICLR, 1'b1, 32'h1);
    chk_rd(OFS_IST, 32'h0);
    chk(irq, 1'b0);
    chk(armed, 1'b0);
    for (int i = 0; i < 256; i += 85) rdb({10'h123, 8'(i)}, pat(i, 10'h123));
    id_reads(8'hfe, 8'hfe);
    rdb(18'h12301, pat(1, 10'h123));
    op(OP_LOCK_LO, 18'h0);
    xfer(OFS_ICLR, 1'b1, 32'h1);
    xfer(OFS_IEN, 1'b1, 32'h0);
    op(OP_LOCK_HI, 18'h3ff00);
    chk_rd(OFS_IST, 32'h1);
    chk(irq, 1'b0);
    xfer(OFS_IEN, 1'b1, 32'h1);
    chk_rd(OFS_IEN, 32'h1);
    chk(irq, 1'b1);
    xfer(OFS_ICLR, 1'b1, 32'h1);
    chk_rd(OFS_IST, 32'h0);
    chk(irq, 1'b0);
    id_reads(8'hff, 8'hff);
    prog(10'h000);
    rdb(18'h00005, 8'hff);
    chk(errs, 32'h0);
    wrap_up;
  end

  // Cut a hang short
  initial begin
    #(60000 * CLK_NS);
    n_fail++;
    wrap_up;
  end
endmodule

/* File: verilog/sfp_engine.sv */
`timescale 1ns/1ns
module sfp_engine (
  input  wire logic                  hclk,          // Clock
  input  wire logic                  hresetn,       // Async reset, active low
  sfp_cyc_if.eng                     cyc,           // Cycle request
  input  wire logic [7:0]            dq_s,          // Synchronised data pins
  output logic [sfp_pkg::FA_W-1:0]   flash_a,       // Address pins
  output logic                       flash_ce_n,    // Chip select
  output logic                       flash_oe_n,    // Output drive strobe
  output logic                       flash_we_n,    // Write strobe
  output logic [7:0]                 flash_dq_o,    // Data out
  output logic                       flash_dq_oe_n  // Data drive, low drives
);
  import sfp_pkg::*;

  sfp_eng_t   st_q;
  logic [3:0] cnt_q;
  logic       we_q;

  // Cycle sequencer: setup, strobe, recovery
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= EG_IDLE;
      cnt_q    <= 4'h0;
      we_q     <= 1'b0;
      cyc.done <= 1'b0;
    end else begin
      cyc.done <= 1'b0;
      case (st_q)
        EG_IDLE: begin
          if (cyc.req) begin
            st_q <= EG_SETUP;
            we_q <= cyc.we;
          end
        end
        EG_SETUP: begin
          st_q  <= EG_STRB;
          cnt_q <= we_q ? 4'(WP_CYC - 1) : 4'(RD_CYC - 1);
        end
        EG_STRB: begin
          if (cnt_q == 4'h0) begin
            st_q  <= EG_RECOV;
            cnt_q <= we_q ? 4'(WPH_CYC - 1) : 4'(OEHP_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        EG_RECOV: begin
          if (cnt_q == 4'h0) begin
            st_q     <= EG_IDLE;
            cyc.done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: st_q <= EG_IDLE;
      endcase
    end
  end

  // Pin drivers; data stays driven through recovery for hold time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_a       <= '0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_dq_o    <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      cyc.rdata     <= 8'h00;
    end else begin
      case (st_q)
        EG_IDLE: begin
          if (cyc.req) begin
            flash_a       <= cyc.addr;
            flash_dq_o    <= cyc.wdata;
            flash_dq_oe_n <= !cyc.we;
            flash_ce_n    <= 1'b0;
          end
        end
        EG_SETUP: begin
          flash_we_n <= !we_q;
          flash_oe_n <= we_q;
        end
        EG_STRB: begin
          if (cnt_q == 4'h0) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            if (!we_q) begin
              cyc.rdata <= dq_s;
            end
          end
        end
        EG_RECOV: begin
          if (cnt_q == 4'h0) begin
            flash_dq_oe_n <= 1'b1;
          end
        end
        default: flash_ce_n <= 1'b1;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  we_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n)
    else $error("write pulse width wrong");
  oe_high_a: assert property (!flash_we_n |-> flash_oe_n && !flash_dq_oe_n)
    else $error("output strobe low during write pulse");
endmodule

/* File: verilog/sfp_host.sv */
`timescale 1ns/1ns
// Operation
// - Sector address on upper lines every load
// - Load all 256 bytes of the sector
// - Next byte load within byte-load window
// - Poll reads keep one fixed address
// - Command words on address 14:0, data 7:0
module sfp_host #(
  parameter int WC_TMO_CYC = sfp_pkg::WC_CYC // Program cycle limit in clocks
) (
  input  wire logic                  hclk,          // Bus clock
  input  wire logic                  hresetn,       // Async reset, active low
  input  wire logic                  hsel,          // Slave select
  input  wire logic [31:0]           haddr,         // Byte address
  input  wire logic [1:0]            htrans,        // Transfer type
  input  wire logic                  hwrite,        // Write when high
  input  wire logic [2:0]            hsize,         // Word only
  input  wire logic [31:0]           hwdata,        // Write data
  input  wire logic                  hready,        // Bus ready
  output logic                       hreadyout,     // Always ready
  output logic                       hresp,         // Always OKAY
  output logic [31:0]                hrdata,        // Read data
  output logic                       irq,           // Level interrupt
  output logic [sfp_pkg::FA_W-1:0]   flash_a,       // Flash address
  output logic                       flash_ce_n,    // Flash chip select
  output logic                       flash_oe_n,    // Flash output strobe
  output logic                       flash_we_n,    // Flash write strobe
  input  wire logic [7:0]            flash_dq_i,    // Flash data in
  output logic [7:0]                 flash_dq_o,    // Flash data out
  output logic                       flash_dq_oe_n  // Flash data drive, low drives
);
  import sfp_pkg::*;

  sfp_cyc_if cyc ();

  sfp_st_t     st_q;
  sfp_op_t     op_q;
  logic [17:0] addr_q;
  logic [1:0]  step_q;
  logic [7:0]  idx_q;
  logic        wait_q;
  logic        tog_q;
  logic        tog_v_q;
  logic        err_q;
  logic        id_mode_q;
  logic [7:0]  rd_byte_q;
  logic [17:0] tmo_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_en_q;
  logic [31:0] buf_q [64];
  logic        dwr_q;
  logic [8:0]  dad_q;
  logic [7:0]  dq_s;
  logic        acc;
  logic        go;
  logic        issue;
  logic        blc_hold;
  logic [22:0] cmd_w;
  logic [1:0]  irq_set;
  logic [1:0]  irq_clr;

  // Data-phase write hit on one of our registers
  function automatic logic wr_hit(input logic wr, input logic [8:0] a,
                                  input logic [8:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  // Command word for a step: two unlock writes then the operation code
  function automatic logic [22:0] cmd_word(input sfp_op_t op, input logic [1:0] s);
    logic [7:0] code;
    case (op)
      OP_ID_IN:   code = CMD_ID_IN;
      OP_ID_OUT:  code = CMD_ID_OUT;
      OP_LOCK_LO: code = CMD_LOCK_LO;
      OP_LOCK_HI: code = CMD_LOCK_HI;
      default:    code = CMD_PROG;
    endcase
    case (s)
      2'd0:    cmd_word = {UNLK_A1, UNLK_D1};
      2'd1:    cmd_word = {UNLK_A2, UNLK_D2};
      default: cmd_word = {CMD_A, code};
    endcase
  endfunction

  // Register read mux; buffer words live above offset 0x100
  function automatic logic [31:0] rd_mux(input logic [8:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a[8]) begin
      v = buf_q[a[7:2]];
    end else begin
      case (a)
        OFS_CTRL: v = {29'h0, op_q};
        OFS_ADDR: v = {14'h0, addr_q};
        OFS_STAT: begin
          v[ST_BUSY_POS]          = (st_q != ST_IDLE);
          v[ST_IDM_POS]           = id_mode_q;
          v[ST_ERR_POS]           = err_q;
          v[ST_RD_POS +: 8]       = rd_byte_q;
        end
        OFS_IST:  v = {30'h0, irq_st_q};
        OFS_IEN:  v = {30'h0, irq_en_q};
        default:  v = 32'h0;
      endcase
    end
    rd_mux = v;
  endfunction

  sfp_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (flash_dq_i),
    .q       (dq_s)
  );

  sfp_engine u_eng (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .cyc           (cyc.eng),
    .dq_s          (dq_s),
    .flash_a       (flash_a),
    .flash_ce_n    (flash_ce_n),
    .flash_oe_n    (flash_oe_n),
    .flash_we_n    (flash_we_n),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_n (flash_dq_oe_n)
  );

  // Bus slave: zero wait states, OKAY only
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel && htrans[1] && hready;
  assign go        = wr_hit(dwr_q, dad_q, OFS_CTRL) && (st_q == ST_IDLE)
                     && (hwdata[2:0] <= 3'(OP_LOCK_HI));

  // Address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_q  <= 1'b0;
      dad_q  <= 9'h000;
      hrdata <= 32'h0;
    end else begin
      dwr_q  <= acc && hwrite;
      dad_q  <= haddr[8:0];
      hrdata <= (acc && !hwrite) ? rd_mux(haddr[8:0]) : 32'h0;
    end
  end

  // Sector buffer, writable only while idle
  always_ff @(posedge hclk) begin
    if (dwr_q && dad_q[8] && (st_q == ST_IDLE)) begin
      buf_q[dad_q[7:2]] <= hwdata;
    end
  end

  // Operation and address registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q     <= OP_READ;
      addr_q   <= 18'h0;
      irq_en_q <= IEN_RST;
    end else begin
      if (go) begin
        op_q <= sfp_op_t'(hwdata[2:0]);
      end
      if (wr_hit(dwr_q, dad_q, OFS_ADDR) && (st_q == ST_IDLE)) begin
        addr_q <= hwdata[17:0];
      end
      if (wr_hit(dwr_q, dad_q, OFS_IEN)) begin
        irq_en_q <= hwdata[1:0];
      end
    end
  end

  // Cycle request towards the engine; after the last load the first poll
  // waits out the byte-load window, since programming only starts then
  assign blc_hold = (st_q == ST_POLL) && (op_q == OP_PROG)
                    && (tmo_q <= 18'(BLC_CYC));
  assign issue = !wait_q && !cyc.done && !blc_hold
                 && (st_q inside {ST_CMD, ST_LOAD, ST_POLL, ST_READ});
  assign cmd_w = cmd_word(op_q, step_q);

  always_comb begin
    cyc.req   = issue;
    cyc.we    = (st_q == ST_CMD) || (st_q == ST_LOAD);
    cyc.addr  = addr_q;
    cyc.wdata = 8'h00;
    case (st_q)
      ST_CMD: begin
        cyc.addr  = {3'b000, cmd_w[22:8]};
        cyc.wdata = cmd_w[7:0];
      end
      ST_LOAD: begin
        cyc.addr  = {addr_q[17:8], idx_q};
        cyc.wdata = buf_q[idx_q[7:2]][{idx_q[1:0], 3'b000} +: 8];
      end
      default: cyc.addr = addr_q;
    endcase
  end

  // Outstanding cycle tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 1'b0;
    end else if (issue) begin
      wait_q <= 1'b1;
    end else if (cyc.done) begin
      wait_q <= 1'b0;
    end
  end

  // Operation sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= ST_IDLE;
      step_q  <= 2'd0;
      idx_q   <= 8'h00;
      tog_q   <= 1'b0;
      tog_v_q <= 1'b0;
      err_q   <= 1'b0;
      tmo_q   <= 18'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            st_q    <= (hwdata[2:0] == 3'(OP_READ)) ? ST_READ : ST_CMD;
            step_q  <= 2'd0;
            idx_q   <= 8'h00;
            tog_v_q <= 1'b0;
            err_q   <= 1'b0;
            tmo_q   <= 18'h0;
          end
        end
        ST_CMD: begin
          if (cyc.done) begin
            if (step_q == 2'd2) begin
              case (op_q)
                OP_PROG:    st_q <= ST_LOAD;
                OP_LOCK_LO: st_q <= ST_POLL;
                OP_LOCK_HI: st_q <= ST_POLL;
                default:    st_q <= ST_FIN;
              endcase
            end else begin
              step_q <= step_q + 2'd1;
            end
          end
        end
        ST_LOAD: begin
          // Loads run back to back, far inside the byte-load window
          if (cyc.done) begin
            if (idx_q == 8'(SECT_BYTES - 1)) begin
              st_q <= ST_POLL;
            end else begin
              idx_q <= idx_q + 8'h01;
            end
          end
        end
        ST_POLL: begin
          if (tmo_q < 18'(WC_TMO_CYC)) begin
            tmo_q <= tmo_q + 18'h1;
          end
          if (cyc.done) begin
            if (tog_v_q && (cyc.rdata[TOG_BIT] == tog_q)) begin
              st_q <= ST_FIN;
            end else if (tmo_q >= 18'(WC_TMO_CYC)) begin
              st_q  <= ST_FIN;
              err_q <= 1'b1;
            end
            tog_q   <= cyc.rdata[TOG_BIT];
            tog_v_q <= 1'b1;
          end
        end
        ST_READ: begin
          if (cyc.done) begin
            st_q <= ST_FIN;
          end
        end
        ST_FIN:  st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Last byte read and identification mode tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte_q <= 8'h00;
      id_mode_q <= 1'b0;
    end else begin
      if (cyc.done && !cyc.we) begin
        rd_byte_q <= cyc.rdata;
      end
      if (st_q == ST_FIN && op_q == OP_ID_IN) begin
        id_mode_q <= 1'b1;
      end else if (st_q == ST_FIN && op_q == OP_ID_OUT) begin
        id_mode_q <= 1'b0;
      end
    end
  end

  // Sticky interrupt status; a set wins over a clear in the same cycle
  assign irq_set = {(st_q == ST_FIN) && err_q, st_q == ST_FIN};
  assign irq_clr = wr_hit(dwr_q, dad_q, OFS_ICLR) ? hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= 2'h0;
    end else begin
      irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
    end
  end

  assign irq = |(irq_st_q & irq_en_q);

  // Checking helpers
  logic [10:0] gap_q;
  logic [8:0]  ld_cnt_q;
  logic [9:0]  sect_h_q;
  logic [17:0] poll_a_q;
  logic        poll_seen_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q       <= 11'h0;
      ld_cnt_q    <= 9'h0;
      sect_h_q    <= 10'h0;
      poll_a_q    <= 18'h0;
      poll_seen_q <= 1'b0;
    end else begin
      gap_q <= issue ? 11'h0 : ((gap_q == 11'h7ff) ? gap_q : gap_q + 11'h1);
      if (st_q == ST_IDLE) begin
        ld_cnt_q    <= 9'h0;
        poll_seen_q <= 1'b0;
        sect_h_q    <= addr_q[17:8];
      end else if (cyc.done && st_q == ST_LOAD) begin
        ld_cnt_q <= ld_cnt_q + 9'h1;
      end
      if (issue && st_q == ST_POLL) begin
        poll_a_q    <= cyc.addr;
        poll_seen_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sect_addr_a: assert property (
    cyc.req && st_q == ST_LOAD |-> cyc.addr[17:8] == sect_h_q)
    else $error("byte load outside sector");
  all_bytes_a: assert property (
    $rose(st_q == ST_POLL) && op_q == OP_PROG |-> ld_cnt_q == 9'd256)
    else $error("program started before all bytes loaded");
  load_gap_a: assert property (
    st_q == ST_LOAD |-> gap_q < 11'd1500)
    else $error("byte-load window exceeded");
  poll_addr_a: assert property (
    cyc.req && st_q == ST_POLL && poll_seen_q |-> cyc.addr == poll_a_q)
    else $error("poll address changed");
  cmd_addr_a: assert property (
    cyc.req && st_q == ST_CMD |-> cyc.we && cyc.addr[17:15] == 3'b000)
    else $error("command word outside low address bits");
  unlock_a: assert property (
    $rose(st_q == ST_LOAD) |-> $past(st_q) == ST_CMD && $past(step_q) == 2'd2)
    else $error("sector load without unlock");
  done_irq_a: assert property (
    st_q == ST_FIN |=> irq_st_q[IRQ_DONE] && st_q == ST_IDLE)
    else $error("completion not flagged");

  prog_done_c: cover property ($rose(st_q == ST_FIN) && op_q == OP_PROG && !err_q);
  prog_tmo_c: cover property ($rose(st_q == ST_FIN) && err_q);
  read_c: cover property (st_q == ST_READ ##[1:40] st_q == ST_FIN);
  id_c: cover property ($rose(id_mode_q));
endmodule

/* File: verilog/sfp_sync.sv */
`timescale 1ns/1ns
module sfp_sync (
  input  wire logic       hclk,    // Clock
  input  wire logic       hresetn, // Async reset, active low
  input  wire logic [7:0] d,       // Pin level
  output logic      [7:0] q        // Settled level
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;

  // Three stages; a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          q[i]    <= 1'b0;
        end else begin
          s1_q[i] <= d[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule
